//--- pkg/lfs_pkg.sv
// Purpose: Shared constants and types for the LED driver sequencing and fault controller
// Assumes: 50 MHz system clock, AXI4-Lite register access
// Notes:   Register offsets are byte addresses of aligned 32-bit words
`default_nettype none
package lfs_pkg;
  localparam int          NUM_CH           = 6;
  localparam int          CLK_HZ           = 50_000_000;
  // Soft-start timing
  localparam int          SS_TOTAL_MS      = 8;
  localparam int          SS_STEPS         = 8;
  localparam int          SS_STEP_CYC      = (SS_TOTAL_MS * (CLK_HZ / 1000) + SS_STEPS - 1) / SS_STEPS;
  localparam logic [3:0]  SS_LIM_STEP_MA_X = 4'h1; // one step of 275 mA
  localparam int          ILIM_STEP_MA     = 275;
  // Open-circuit time-outs in PWM periods
  localparam logic [3:0]  OPEN_TMO_PWM     = 4'h6;
  localparam logic [3:0]  OPEN_TMO_HOT     = 4'h2;
  // Output short shutdown delay
  localparam int          SHORT_SD_MS      = 31;
  localparam int          SHORT_SD_CYC     = SHORT_SD_MS * (CLK_HZ / 1000);
  // Register map
  localparam logic [7:0]  REG_CTRL         = 8'h00;
  localparam logic [7:0]  REG_STATUS       = 8'h04;
  localparam logic [7:0]  REG_CHGOOD       = 8'h08;
  localparam logic [7:0]  REG_CHOPEN       = 8'h0c;
  localparam logic [7:0]  REG_CHOFF        = 8'h10;
  localparam logic [31:0] CTRL_RST         = 32'h0000_0000;
  localparam int          CTRL_SWEN_BIT    = 0;
  localparam int          CTRL_SLOWSS_BIT  = 1;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  typedef enum logic [2:0] {
    LFS_IDLE  = 3'h0,
    LFS_INRSH = 3'h1,
    LFS_SOFT  = 3'h3,
    LFS_RUN   = 3'h2,
    LFS_HOT   = 3'h6,
    LFS_DEAD  = 3'h7
  } lfs_state_t;

  typedef struct packed {
    logic ovp;
    logic ot_low;
    logic ot_high;
    logic input_undervoltage_lockout;
    logic in_ocp;
    logic out_short;
    logic ovp_dip;
    logic stable;
  } lfs_sense_t;
endpackage
`default_nettype wire

//--- src/lfs_ctrl.sv
// Purpose: Start-up sequencing, soft-start and channel fault handling of a 6-string LED driver
// Assumes: Analog comparator levels arrive asynchronously and are synchronised here
// Notes:   Analog loops are outside; this block only gates and classifies
// Behaviour
// [RQ1] Channel enables follow dimming PWM directly
// [RQ2] Current limit steps 275 mA to 2.2 A
// [RQ3] Soft-start at least 8 ms, slower when dim
// [RQ4] Switching waits for protection switch fully on
// [RQ5] Over-limit current ends on-time each cycle
// [RQ6] Fault flag latches on any fault event; here in_ocp and ovp_dip do not set it
// [RQ7] Flag clears only by power or re-enable
// [RQ8] Channel good once current reaches target
// [RQ9] Good channel dropping below target becomes open
// [RQ10] Overvoltage or low overtemp marks non-good open
// [RQ11] Open channel disabled after time-out only
// [RQ12] Shorter time-out above low overtemp threshold
// [RQ13] Channel above short threshold is disabled
// [RQ14] Fault decisions held off while unstable
// [RQ15] One faulted channel leaves others running
// [RQ16] Raised-voltage string stays on without overvoltage
// [RQ17] Input overcurrent shuts all channels down
// [RQ18] Boost short turns protection switch off
// [RQ19] Undervoltage stops switching and resets state
// [RQ20] Open time-out counts six PWM periods
// [RQ21] Output short shuts down after 31 ms
// [RQ22] Overvoltage-node dip turns protection switch off
// [RQ23] Upper overtemp stops all, restarts derated
// [RQ24] Disable resets sequencer and channel states
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module lfs_ctrl #(
  parameter int SHORT_SD_CYC_P = lfs_pkg::SHORT_SD_CYC,
  parameter int SS_STEP_CYC_P  = lfs_pkg::SS_STEP_CYC
) (
  input  wire logic               CLK_SYS_I,
  input  wire logic               SRST_I,
  input  wire logic               EN_I,
  input  wire logic               PWM_I,
  input  wire logic               PSW_ON_I,
  input  wire logic               SW_OVER_I,
  input  wire logic [5:0]         CH_AT_TARGET_I,
  input  wire logic [5:0]         CH_SHORT_I,
  input  wire lfs_pkg::lfs_sense_t SENSE_I,
  output logic [5:0]              CH_EN_O,
  output logic                    BOOST_EN_O,
  output logic                    BOOST_ON_O,
  output logic [3:0]              ILIM_STEP_O,
  output logic [1:0]              DERATE_O,
  output logic                    FLAG_N_O,
  output logic                    FLAG_OE_O,
  output logic                    PSW_OFF_O,
  input  wire logic [7:0]         S_AXI_AWADDR,
  input  wire logic               S_AXI_AWVALID,
  output logic                    S_AXI_AWREADY,
  input  wire logic [31:0]        S_AXI_WDATA,
  input  wire logic [3:0]         S_AXI_WSTRB,
  input  wire logic               S_AXI_WVALID,
  output logic                    S_AXI_WREADY,
  output logic [1:0]              S_AXI_BRESP,
  output logic                    S_AXI_BVALID,
  input  wire logic               S_AXI_BREADY,
  input  wire logic [7:0]         S_AXI_ARADDR,
  input  wire logic               S_AXI_ARVALID,
  output logic                    S_AXI_ARREADY,
  output logic [31:0]             S_AXI_RDATA,
  output logic [1:0]              S_AXI_RRESP,
  output logic                    S_AXI_RVALID,
  input  wire logic               S_AXI_RREADY
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int SW = 24;
  logic [SW-1:0] s1_reg;
  logic [SW-1:0] s2_reg;
  wire  [SW-1:0] raw_in = {EN_I, PWM_I, PSW_ON_I, SW_OVER_I, CH_AT_TARGET_I, CH_SHORT_I, SENSE_I};
  always_ff @(posedge CLK_SYS_I) begin
    s1_reg <= raw_in;
    s2_reg <= s1_reg;
  end
  wire              en_s     = s2_reg[23];
  wire              pwm_s    = s2_reg[22];
  wire              psw_on_s = s2_reg[21];
  wire              sw_ovr_s = s2_reg[20];
  wire [5:0]        tgt_s    = s2_reg[19:14];
  wire [5:0]        shrt_s   = s2_reg[13:8];
  lfs_pkg::lfs_sense_t sn;
  assign sn = s2_reg[7:0];

  // ****************************************
  // Register file over AXI4-Lite
  // ****************************************
  logic [31:0] ctrl_reg;
  logic        aw_got_reg;
  logic        w_got_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  wire         wr_go   = aw_got_reg && w_got_reg && !S_AXI_BVALID;
  wire         wr_ctrl = wr_go && (awaddr_reg == lfs_pkg::REG_CTRL);
  wire         wr_map  = (awaddr_reg == lfs_pkg::REG_CTRL);
  wire         sw_en   = ctrl_reg[lfs_pkg::CTRL_SWEN_BIT];
  wire         slow_ss = ctrl_reg[lfs_pkg::CTRL_SLOWSS_BIT];
  wire [31:0]  ctrl_wr;
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_be
      assign ctrl_wr[gb*8 +: 8] = wstrb_reg[gb] ? wdata_reg[gb*8 +: 8] : ctrl_reg[gb*8 +: 8];
    end
  endgenerate
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
      ctrl_reg   <= lfs_pkg::CTRL_RST;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= lfs_pkg::RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_reg <= 1'b1;
        wdata_reg <= S_AXI_WDATA;
        wstrb_reg <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_map ? lfs_pkg::RESP_OKAY : lfs_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl_reg <= ctrl_wr;
      end
    end
  end
  assign S_AXI_AWREADY = !aw_got_reg && !SRST_I;
  assign S_AXI_WREADY  = !w_got_reg && !SRST_I;

  // ****************************************
  // Sequencer
  // ****************************************
  lfs_pkg::lfs_state_t st_reg;
  lfs_pkg::lfs_state_t st_next;
  logic [3:0]  ilim_reg;
  logic [1:0]  derate_reg;
  logic [31:0] ss_cnt_reg;
  logic [31:0] sd_cnt_reg;
  logic        flag_reg;
  logic        psw_off_reg;
  logic        ovp_hi_seen_reg;
  logic        pwm_d_reg;
  logic [5:0]  good_reg;
  logic [5:0]  open_reg;
  logic [5:0]  off_reg;
  localparam int NCH_L = lfs_pkg::NUM_CH;
  logic [3:0]  tmo_reg [NCH_L-1:0];

  wire active   = en_s && sw_en && !sn.input_undervoltage_lockout;                 // [RQ19] [RQ24]
  wire pwm_rise = pwm_s && !pwm_d_reg;
  // Dim operation stretches each step until PWM is high too
  wire dim      = slow_ss && !pwm_s;                         // [RQ3]
  wire ss_tick  = (ss_cnt_reg >= 32'(SS_STEP_CYC_P - 1)) && (!dim || pwm_rise);
  wire running  = (st_reg == lfs_pkg::LFS_SOFT) || (st_reg == lfs_pkg::LFS_RUN);
  wire ovp_dip  = ovp_hi_seen_reg && sn.ovp_dip;
  wire boost_sc = sn.out_short && (sd_cnt_reg >= 32'(SHORT_SD_CYC_P - 1)); // [RQ21]
  wire any_flt  = (|(open_reg & tgt_s) == 1'b0 && |open_reg) || |(shrt_s & good_reg)
                  || sn.ovp || sn.ot_low || sn.ot_high || sn.out_short;

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      lfs_pkg::LFS_IDLE:  if (active) st_next = lfs_pkg::LFS_INRSH;
      lfs_pkg::LFS_INRSH: if (psw_on_s) st_next = lfs_pkg::LFS_SOFT;     // [RQ4]
      lfs_pkg::LFS_SOFT:  if (ss_tick && ilim_reg == 4'h8) st_next = lfs_pkg::LFS_RUN;
      lfs_pkg::LFS_RUN:   st_next = lfs_pkg::LFS_RUN;
      lfs_pkg::LFS_HOT:   if (!sn.ot_high) st_next = lfs_pkg::LFS_INRSH; // [RQ23]
      lfs_pkg::LFS_DEAD:  st_next = lfs_pkg::LFS_DEAD;
      default:            st_next = lfs_pkg::LFS_IDLE;
    endcase
    if (running && sn.ot_high) st_next = lfs_pkg::LFS_HOT;               // [RQ23]
    if (running && boost_sc) st_next = lfs_pkg::LFS_DEAD;               // [RQ21]
    if (!active) st_next = lfs_pkg::LFS_IDLE;                            // [RQ19] [RQ24]
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      st_reg          <= lfs_pkg::LFS_IDLE;
      ilim_reg        <= 4'h0;
      derate_reg      <= 2'h0;
      ss_cnt_reg      <= 32'h0000_0000;
      sd_cnt_reg      <= 32'h0000_0000;
      flag_reg        <= 1'b0;
      psw_off_reg     <= 1'b0;
      ovp_hi_seen_reg <= 1'b0;
      pwm_d_reg       <= 1'b0;
    end else begin
      st_reg    <= st_next;
      pwm_d_reg <= pwm_s;
      if (st_next == lfs_pkg::LFS_SOFT && st_reg != lfs_pkg::LFS_SOFT) begin
        ilim_reg   <= lfs_pkg::SS_LIM_STEP_MA_X;                       // [RQ2]
        ss_cnt_reg <= 32'h0000_0000;
      end else if (st_reg == lfs_pkg::LFS_SOFT) begin
        ss_cnt_reg <= ss_tick ? 32'h0000_0000 : ss_cnt_reg + 32'h0000_0001;
        if (ss_tick && ilim_reg != 4'h8) ilim_reg <= ilim_reg + 4'h1;  // [RQ2] [RQ3]
      end
      if (!active) begin
        ilim_reg        <= 4'h0;
        derate_reg      <= 2'h0;
        flag_reg        <= 1'b0;                                        // [RQ7]
        psw_off_reg     <= 1'b0;
        ovp_hi_seen_reg <= 1'b0;
        sd_cnt_reg      <= 32'h0000_0000;
      end else begin
        if (any_flt) flag_reg <= 1'b1;                                  // [RQ6]
        if (st_reg != lfs_pkg::LFS_HOT && st_next == lfs_pkg::LFS_HOT && derate_reg != 2'h3)
          derate_reg <= derate_reg + 2'h1;                              // [RQ23]
        if (sn.out_short && sd_cnt_reg < 32'(SHORT_SD_CYC_P))
          sd_cnt_reg <= sd_cnt_reg + 32'h0000_0001;
        if (!sn.ovp_dip) ovp_hi_seen_reg <= 1'b1;
        if (boost_sc || ovp_dip) psw_off_reg <= 1'b1;                   // [RQ18] [RQ22]
      end
    end
  end

  // ****************************************
  // Per-channel good/open tracking
  // ****************************************
  wire open_all = sn.ovp || sn.ot_low;                                   // [RQ10] [RQ16]
  wire [3:0] tmo_lim = sn.ot_low ? lfs_pkg::OPEN_TMO_HOT : lfs_pkg::OPEN_TMO_PWM; // [RQ12] [RQ20]
  genvar gc;
  generate
    for (gc = 0; gc < NCH_L; gc++) begin : g_ch
      always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I || !active) begin                                     // [RQ24]
          good_reg[gc] <= 1'b0;
          open_reg[gc] <= 1'b0;
          off_reg[gc]  <= 1'b0;
          tmo_reg[gc]  <= 4'h0;
        end else if (running && sn.stable && !off_reg[gc]) begin         // [RQ14] [RQ15]
          if (tgt_s[gc]) good_reg[gc] <= 1'b1;                           // [RQ8]
          if (shrt_s[gc] && pwm_s) off_reg[gc] <= 1'b1;                  // [RQ13]
          if ((good_reg[gc] && !tgt_s[gc] && pwm_s) || (!good_reg[gc] && open_all))
            open_reg[gc] <= 1'b1;                                        // [RQ9] [RQ10]
          if (open_reg[gc] && pwm_rise) begin
            if (tmo_reg[gc] >= tmo_lim - 4'h1) off_reg[gc] <= 1'b1;      // [RQ11] [RQ20]
            else tmo_reg[gc] <= tmo_reg[gc] + 4'h1;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      CH_EN_O     <= 6'h00;
      BOOST_EN_O  <= 1'b0;
      BOOST_ON_O  <= 1'b0;
      ILIM_STEP_O <= 4'h0;
      DERATE_O    <= 2'h0;
      FLAG_N_O    <= 1'b0;
      FLAG_OE_O   <= 1'b0;
      PSW_OFF_O   <= 1'b0;
    end else begin
      // PWM is not resampled, only delayed by the synchroniser and this output register
      CH_EN_O     <= (running && !sn.in_ocp) ? ({6{pwm_s}} & ~off_reg) : 6'h00; // [RQ1] [RQ15] [RQ17]
      BOOST_EN_O  <= running && !sn.in_ocp;                              // [RQ4] [RQ17]
      BOOST_ON_O  <= running && !sn.in_ocp && !sw_ovr_s;                // [RQ5]
      ILIM_STEP_O <= ilim_reg;
      DERATE_O    <= derate_reg;
      FLAG_N_O    <= 1'b0;
      FLAG_OE_O   <= flag_reg;                                           // [RQ6]
      PSW_OFF_O   <= psw_off_reg;                                        // [RQ18]
    end
  end

  // Read channel
  logic [31:0] rd_mux;
  assign rd_mux = (S_AXI_ARADDR == lfs_pkg::REG_CTRL)   ? ctrl_reg :
                  (S_AXI_ARADDR == lfs_pkg::REG_STATUS) ?
                    {20'h00000, derate_reg, ilim_reg, flag_reg, psw_off_reg, 1'b0, st_reg} :
                  (S_AXI_ARADDR == lfs_pkg::REG_CHGOOD) ? {26'h0, good_reg} :
                  (S_AXI_ARADDR == lfs_pkg::REG_CHOPEN) ? {26'h0, open_reg} :
                  (S_AXI_ARADDR == lfs_pkg::REG_CHOFF)  ? {26'h0, off_reg}  : 32'h0000_0000;
  wire rd_map = (S_AXI_ARADDR <= lfs_pkg::REG_CHOFF) && (S_AXI_ARADDR[1:0] == 2'h0);
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= lfs_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rd_mux;
      S_AXI_RRESP  <= rd_map ? lfs_pkg::RESP_OKAY : lfs_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end
  assign S_AXI_ARREADY = !S_AXI_RVALID && !SRST_I;

  // ****************************************
  // Checks
  // ****************************************
  sequence inrush_done_s;
    st_reg == lfs_pkg::LFS_INRSH && psw_on_s && active;
  endsequence
  ilim_start_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ2]
    inrush_done_s |=> ilim_reg == 4'h1) else $error("soft-start not at lowest step");
  ilim_top_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ2]
    ilim_reg <= 4'h8) else $error("current limit above top step");
  boost_wait_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ4]
    st_reg == lfs_pkg::LFS_INRSH |=> !BOOST_EN_O) else $error("boost before in-rush end");
  sw_cut_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ5]
    sw_ovr_s |=> !BOOST_ON_O) else $error("on-time not ended");
  flag_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ7]
    flag_reg && active |=> flag_reg) else $error("flag released");
  flag_set_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ6]
    active && sn.ovp |=> flag_reg) else $error("flag not latched");
  ocp_off_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ17]
    sn.in_ocp |=> CH_EN_O == 6'h00) else $error("channels on during overcurrent");
  input_undervoltage_lockout_rst_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ19]
    sn.input_undervoltage_lockout |=> st_reg == lfs_pkg::LFS_IDLE ##1 !BOOST_EN_O) else $error("no lockout");
  dis_clear_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ24]
    !active |=> good_reg == 6'h00 && open_reg == 6'h00) else $error("channels not reset");
  pwm_pass_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ1]
    running && !sn.in_ocp && !pwm_s |=> CH_EN_O == 6'h00) else $error("PWM not followed");
  psw_dip_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ22]
    active && ovp_dip |=> psw_off_reg) else $error("protection switch left on");
  // A shorted pin is only judged during on-time, when its voltage means something
  short_off_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // [RQ13]
    active && running && sn.stable && pwm_s |=> (off_reg & $past(shrt_s)) == $past(shrt_s))
    else $error("shorted channel left on");
endmodule
`default_nettype wire

//--- tb/lfs_partner.sv
// Purpose: Far-side model: dimming PWM source and input protection switch
// Assumes: Duty given in clock cycles out of PERIOD_P
// Notes:   Switch reports fully on a fixed time after enable
`timescale 1ns/1ps
`default_nettype none
module lfs_partner #(
  parameter int PERIOD_P = 40,
  parameter int PSW_DLY_P = 10
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       en_i,
  input  wire logic       psw_off_i,
  input  wire logic [7:0] duty_i,
  output logic            pwm_o,
  output logic            psw_on_o
);
  int cnt;
  int psw_cnt;
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 0;
      psw_cnt <= 0;
      pwm_o <= 1'b0;
      psw_on_o <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD_P - 1) ? 0 : cnt + 1;
      pwm_o <= (cnt < int'(duty_i));
      // Gate slowly enhances only while enabled and not tripped off
      if (!en_i || psw_off_i) begin
        psw_cnt <= 0;
      end else if (psw_cnt < PSW_DLY_P) begin
        psw_cnt <= psw_cnt + 1;
      end
      psw_on_o <= en_i && !psw_off_i && (psw_cnt >= PSW_DLY_P);
    end
  end
endmodule
`default_nettype wire

//--- tb/lfs_ctrl_test.sv
// Purpose: Self-checking bench of the sequencing and fault controller
// Assumes: Short soft-start and short-circuit counts via parameters
// Notes:   PWM period 40 cycles, so six periods fit in a short run
`timescale 1ns/1ps
`default_nettype none
module lfs_ctrl_test;
  localparam int SS = 20;
  localparam int PER = 40;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, sw_over = 1'b0;
  logic pwm, psw_on;
  logic [5:0] tgt = 6'h00, shrt = 6'h00, ch_en;
  logic [7:0] duty = 8'h14;
  lfs_pkg::lfs_sense_t sense = '0;
  logic boost_en, boost_on, flag_n, flag_oe, psw_off;
  logic [3:0] ilim;
  logic [1:0] derate, bresp, rresp, r;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0, rdata, d;
  int errors = 0, comparisons = 0, seed = 32'h774f, mask = 0, acc;
  logic pq[$];
  always #10 clk = ~clk;
  lfs_partner #(.PERIOD_P(PER), .PSW_DLY_P(10)) far (.clk_i(clk), .rst_i(rst), .en_i(en),
    .psw_off_i(psw_off), .duty_i(duty), .pwm_o(pwm), .psw_on_o(psw_on));
  lfs_ctrl #(.SHORT_SD_CYC_P(50), .SS_STEP_CYC_P(SS)) dut (.CLK_SYS_I(clk), .SRST_I(rst),
    .EN_I(en), .PWM_I(pwm), .PSW_ON_I(psw_on), .SW_OVER_I(sw_over), .CH_AT_TARGET_I(tgt),
    .CH_SHORT_I(shrt), .SENSE_I(sense), .CH_EN_O(ch_en), .BOOST_EN_O(boost_en),
    .BOOST_ON_O(boost_on), .ILIM_STEP_O(ilim), .DERATE_O(derate), .FLAG_N_O(flag_n),
    .FLAG_OE_O(flag_oe), .PSW_OFF_O(psw_off), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic hang;
    errors++;
    stop_test();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 100) hang();
    rs = bresp; bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 100) hang();
    v = rdata; rs = rresp; rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a, d, r);
    check(d, exp);
  endtask
  // Soft-start ladder: eight steps of one unit, each of the first seven held at least SS cycles
  task automatic ss_track;
    int n, t, k;
    logic [3:0] last;
    last = ilim; t = 0; k = 0;
    for (n = 0; n < 3000 && k < 8; n++) begin
      @(posedge clk);
      t++;
      if (ilim !== last) begin
        k++;
        check(ilim, k);
        if (k > 1) check(t >= SS, 1'b1);
        last = ilim; t = 0;
      end
    end
    if (k < 8) hang();
  endtask
  // Reference: enables equal the PWM input three samples back, on live channels
  always @(negedge clk) begin
    pq.push_back(pwm);
    if (pq.size() > 4) void'(pq.pop_front());
    if (mask != 0 && pq.size() == 4) check(ch_en & mask[5:0], pq[0] ? mask[5:0] : 6'h00);
  end
  initial begin
    cyc(100000);
    hang();
  end
  initial begin
    cyc(3);
    rst <= 1'b0;
    cyc(1);
    rd(lfs_pkg::REG_CTRL, d, r);
    check(d, lfs_pkg::CTRL_RST);
    check(r, lfs_pkg::RESP_OKAY);
    wr(lfs_pkg::REG_CTRL, 32'h1, r);
    rdchk(lfs_pkg::REG_CTRL, 32'h1);
    rd(8'h20, d, r);
    check(r, lfs_pkg::RESP_SLVERR);
    wr(8'h24, 32'h5, r);
    check(r, lfs_pkg::RESP_SLVERR);
    duty <= 8'h08 + 8'($unsigned($random(seed)) % 24);
    sense.stable <= 1'b1;
    en <= 1'b1;
    cyc(8);
    check(boost_en, 1'b0);
    ss_track();
    tgt <= 6'h1f;
    cyc(10);
    rdchk(lfs_pkg::REG_CHGOOD, 32'h1f);
    mask = 6'h3e;
    cyc(2 * PER);
    tgt <= 6'h1e;
    // Drop is only judged while PWM is high, so allow a full period
    cyc(PER + 6);
    rdchk(lfs_pkg::REG_CHOPEN, 32'h01);
    cyc(2 * PER);
    rdchk(lfs_pkg::REG_CHOFF, 32'h00);
    cyc(6 * PER);
    rdchk(lfs_pkg::REG_CHOFF, 32'h01);
    check(flag_oe, 1'b1);
    check(flag_n, 1'b0);
    sense.ovp <= 1'b1;
    cyc(4);
    sense.ovp <= 1'b0;
    cyc(4);
    rdchk(lfs_pkg::REG_CHOPEN, 32'h21);
    mask = 6'h1e;
    shrt <= 6'h04;
    mask = 6'h1a;
    cyc(8 * PER);
    rdchk(lfs_pkg::REG_CHOFF, 32'h25);
    duty <= 8'h08 + 8'($unsigned($random(seed)) % 24);
    cyc(2 * PER);
    mask = 0;
    sw_over <= 1'b1;
    cyc(5);
    check(boost_on, 1'b0);
    sw_over <= 1'b0;
    shrt <= 6'h00;
    cyc(40);
    check(flag_oe, 1'b1);
    en <= 1'b0;
    cyc(8);
    check(flag_oe, 1'b0);
    rdchk(lfs_pkg::REG_CHOFF, 32'h00);
    rdchk(lfs_pkg::REG_CHGOOD, 32'h00);
    check(ilim, 4'h0);
    // Slow soft-start from here on, steps may wait for PWM
    wr(lfs_pkg::REG_CTRL, 32'h3, r);
    check(r, lfs_pkg::RESP_OKAY);
    tgt <= 6'h3f;
    en <= 1'b1;
    ss_track();
    sense.input_undervoltage_lockout <= 1'b1;
    cyc(6);
    check(boost_en, 1'b0);
    check(ilim, 4'h0);
    sense.input_undervoltage_lockout <= 1'b0;
    ss_track();
    sense.ot_high <= 1'b1;
    cyc(6);
    check({boost_en, ch_en}, 7'h00);
    sense.ot_high <= 1'b0;
    cyc(400);
    check(derate, 2'h1);
    sense.in_ocp <= 1'b1;
    cyc(5);
    acc = 0;
    repeat (PER) begin
      @(posedge clk);
      acc = acc | ch_en;
    end
    check(acc, 0);
    sense.in_ocp <= 1'b0;
    sense.out_short <= 1'b1;
    for (acc = 0; acc < 200 && psw_off !== 1'b1; acc++) @(posedge clk);
    check(psw_off, 1'b1);
    check(boost_en, 1'b0);
    en <= 1'b0;
    sense.out_short <= 1'b0;
    cyc(8);
    check(psw_off, 1'b0);
    en <= 1'b1;
    ss_track();
    cyc(10);
    sense.ot_low <= 1'b1;
    tgt <= 6'h3e;
    cyc(4 * PER);
    rdchk(lfs_pkg::REG_CHOFF, 32'h01);
    sense.ot_low <= 1'b0;
    sense.ovp_dip <= 1'b1;
    cyc(6);
    check(psw_off, 1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
